// file: rtl/ehr_device.sv
// Device end: reset detection, strobe control, preload limit, flash status handling.
// Assumes it is clocked by the host-made link clock and sees reset_n on that clock.
//
// Operation
// RQ1 - HS400 response is timed by data strobe
// RQ2 - Strobe toggles only for reads, CRC status; code also toggles it while resp_pending is set
// RQ3 - Rising reset edge starts internal reset
// RQ4 - Host holds reset low/high at least 1 us
// RQ5 - Host waits 200 us before first command
// RQ6 - Host gives 74 clocks before init command
// RQ7 - Reset ignored until enable config loaded
// RQ8 - Preload capped at reported limit field
// RQ9 - Enhanced partition updates preload limit
// RQ10 - Retire block on program/erase status failure
// RQ11 - Check status after every program/erase
// RQ12 - Correct errors on all flash reads
// RQ13 - After reset, return idle awaiting init command
`timescale 1ns/10ps
module ehr_device #(
	parameter int LOAD_CYCLES = ehr_pkg::INIT_LOAD_CYCLES,
	parameter int STROBES     = ehr_pkg::RESP_STROBES
) (
	// Link
	ehr_link_if.device link,
	// Device-side user port
	input  wire logic        rst,
	input  wire logic        reset_pin_enable,
	input  wire logic        enh_partition_set,
	input  wire logic        read_active,
	input  wire logic        crc_status_active,
	input  wire logic [3:0]  preload_request,
	input  wire logic        flash_op_done,
	input  wire logic        flash_op_fail,
	input  wire logic        flash_read_valid,
	input  wire logic        flash_read_err,
	output logic [3:0]       preload_limit,
	output logic [3:0]       preload_granted,
	output logic             block_retire,
	output logic             read_corrected,
	output logic             in_reset
);
	// ==========================================
	// Parameter check
	if (LOAD_CYCLES < 1 || LOAD_CYCLES > 32 || STROBES < 1 || STROBES > 64)
	begin : g_bad_param
		$error("ehr_device parameter out of range");
	end

	// ==========================================
	// Reset pin synchroniser
	logic [2:0] rst_sync;
	logic       rst_level;
	logic       enable_loaded;
	logic [4:0] load_count;
	ehr_pkg::ehr_dev_state_t state;
	ehr_pkg::ehr_dev_state_t next_state;
	logic [5:0] strobe_count;
	logic       strobe;
	logic       resp_pending;

	wire rise_seen = (rst_sync[2:1] == 2'b11) && !rst_level;
	wire fall_seen = (rst_sync[2:1] == 2'b00) && rst_level;
	wire reset_rise = rise_seen && enable_loaded && reset_pin_enable; // RQ3 RQ7
	wire init_cmd = link.cmd_valid && (link.cmd_index == ehr_pkg::CMD_SEND_OP ||
		(link.cmd_index == ehr_pkg::CMD_GO_IDLE && link.cmd_arg != ehr_pkg::ARG_BOOT_INIT));
	wire strobe_on = link.hs400 && (read_active || crc_status_active || resp_pending); // RQ1 RQ2

	always_ff @(posedge link.link_clock or posedge rst)
	begin
		if (rst)
		begin
			rst_sync  <= 3'h0;
			rst_level <= 1'b0;
		end
		else
		begin
			rst_sync <= {rst_sync[1:0], link.reset_n};
			if (rise_seen)
				rst_level <= 1'b1;
			else if (fall_seen)
				rst_level <= 1'b0;
		end
	end

	// ==========================================
	// Enable configuration load after power-on
	always_ff @(posedge link.link_clock or posedge rst)
	begin
		if (rst)
		begin
			load_count    <= 5'h00;
			enable_loaded <= 1'b0;
		end
		else if (!enable_loaded)
		begin
			load_count <= load_count + 5'h01;
			if (load_count == 5'(LOAD_CYCLES - 1))
				enable_loaded <= 1'b1; // RQ7
		end
	end

	// ==========================================
	// State machine
	always_comb
	begin
		next_state = state;
		case (state)
			ehr_pkg::EHR_INIT:  next_state = enable_loaded ? ehr_pkg::EHR_IDLE : ehr_pkg::EHR_INIT;
			ehr_pkg::EHR_RESET: next_state = ehr_pkg::EHR_IDLE; // RQ13
			ehr_pkg::EHR_IDLE:  next_state = init_cmd ? ehr_pkg::EHR_READY : ehr_pkg::EHR_IDLE;
			ehr_pkg::EHR_READY: next_state = ehr_pkg::EHR_READY;
			ehr_pkg::EHR_BUSY:  next_state = ehr_pkg::EHR_READY;
			default:            next_state = ehr_pkg::EHR_INIT;
		endcase
		if (reset_rise)
			next_state = ehr_pkg::EHR_RESET; // RQ3
	end

	always_ff @(posedge link.link_clock or posedge rst)
	begin
		if (rst)
			state <= ehr_pkg::EHR_INIT;
		else
			state <= next_state;
	end

	// ==========================================
	// Response and data strobe
	wire       resp_start  = link.cmd_valid && link.hs400; // RQ1
	wire       window_end  = resp_pending && (strobe_count == 6'h00);
	wire       next_strobe = strobe_on ? ~strobe : 1'b0; // RQ2

	always_ff @(posedge link.link_clock or posedge rst)
	begin
		if (rst)
		begin
			link.resp_valid <= 1'b0;
			link.dev_ready  <= 1'b0;
		end
		else
		begin
			link.resp_valid <= link.cmd_valid && state != ehr_pkg::EHR_RESET; // RQ1
			link.dev_ready  <= (next_state == ehr_pkg::EHR_READY); // RQ13
		end
	end

	always_ff @(posedge link.link_clock or posedge rst)
	begin
		if (rst)
		begin
			strobe_count <= 6'h00;
			resp_pending <= 1'b0;
		end
		else if (resp_start)
		begin
			resp_pending <= 1'b1; // RQ1
			strobe_count <= 6'(STROBES - 1);
		end
		else if (resp_pending)
		begin
			strobe_count <= strobe_count - 6'h01;
			if (window_end)
				resp_pending <= 1'b0;
		end
	end

	always_ff @(posedge link.link_clock or posedge rst)
	begin
		if (rst)
			strobe <= 1'b0;
		else
			strobe <= next_strobe; // RQ2
	end
	assign link.data_strobe_out = strobe;

	// ==========================================
	// Preload limit
	wire [3:0] next_granted = (preload_request > preload_limit) ? preload_limit
		: preload_request; // RQ8

	always_ff @(posedge link.link_clock or posedge rst)
	begin
		if (rst)
		begin
			preload_limit   <= ehr_pkg::PRELOAD_RESET;
			preload_granted <= 4'h0;
		end
		else
		begin
			if (enh_partition_set)
				preload_limit <= ehr_pkg::PRELOAD_ENH; // RQ9
			preload_granted <= next_granted; // RQ8
		end
	end

	// ==========================================
	// Flash status, read correction and reset marker
	wire retire_now  = flash_op_done && flash_op_fail; // RQ10 RQ11
	wire correct_now = flash_read_valid && flash_read_err; // RQ12
	wire reset_now   = (next_state == ehr_pkg::EHR_RESET);

	always_ff @(posedge link.link_clock or posedge rst)
	begin
		if (rst)
		begin
			block_retire   <= 1'b0;
			read_corrected <= 1'b0;
			in_reset       <= 1'b0;
		end
		else
		begin
			block_retire   <= retire_now; // RQ10 RQ11
			read_corrected <= correct_now; // RQ12
			in_reset       <= reset_now; // RQ3
		end
	end
endmodule

// file: rtl/ehr_pkg.sv
// Shared constants for the storage-module reset and strobe link.
// Assumes a 250 MHz system clock on the host end and a slower link clock.
package ehr_pkg;
	// ==========================================
	// Timing
	localparam int CLOCK_MHZ              = 250;
	localparam int RESET_LOW_WIDTH_US     = 1;
	localparam int RESET_HIGH_INTERVAL_US = 1;
	localparam int RESET_TO_COMMAND_US    = 200;
	localparam int INIT_CLOCK_CYCLES      = 74;
	localparam int RESET_LOW_CYCLES       = RESET_LOW_WIDTH_US * CLOCK_MHZ;
	localparam int RESET_HIGH_CYCLES      = RESET_HIGH_INTERVAL_US * CLOCK_MHZ;
	localparam int RESET_TO_COMMAND_WAIT  = RESET_TO_COMMAND_US * CLOCK_MHZ;
	// ==========================================
	// Commands and fields
	localparam logic [5:0]  CMD_GO_IDLE    = 6'h00;
	localparam logic [5:0]  CMD_SEND_OP    = 6'h01;
	localparam logic [31:0] ARG_BOOT_INIT  = 32'hfffffffa;
	localparam int          PRELOAD_LSB    = 18;
	localparam int          PRELOAD_MSB    = 21;
	localparam logic [3:0]  PRELOAD_RESET  = 4'h8;
	localparam logic [3:0]  PRELOAD_ENH    = 4'h4;
	localparam int          INIT_LOAD_CYCLES = 16;
	localparam int          RESP_STROBES   = 48;
	// ==========================================
	// Device states
	typedef enum logic [2:0] {EHR_INIT, EHR_IDLE, EHR_RESET, EHR_READY, EHR_BUSY} ehr_dev_state_t;
endpackage

// file: rtl/ehr_link_if.sv
// Link between host controller and storage device.
// Assumes the host makes the link clock and drives reset and commands.
`timescale 1ns/10ps
interface ehr_link_if;
	logic        link_clock;
	logic        reset_n;
	logic        cmd_valid;
	logic [5:0]  cmd_index;
	logic [31:0] cmd_arg;
	logic        hs400;
	logic        data_strobe_out;
	logic        resp_valid;
	logic        dev_ready;
	modport host (output link_clock, output reset_n, output cmd_valid, output cmd_index,
		output cmd_arg, output hs400, input data_strobe_out, input resp_valid,
		input dev_ready);
	modport device (input link_clock, input reset_n, input cmd_valid, input cmd_index,
		input cmd_arg, input hs400, output data_strobe_out, output resp_valid,
		output dev_ready);
endinterface

// file: rtl/ehr_host.sv
// Host end: divides its clock into the link clock, times reset and first command.
// Assumes a 250 MHz system clock and a device on the far side of the interface.
`timescale 1ns/10ps
module ehr_host #(
	parameter int LOW_CYCLES  = ehr_pkg::RESET_LOW_CYCLES,
	parameter int HIGH_CYCLES = ehr_pkg::RESET_HIGH_CYCLES,
	parameter int WAIT_CYCLES = ehr_pkg::RESET_TO_COMMAND_WAIT,
	parameter int CLK_DIV     = 10
) (
	// System
	input  wire logic        clock,
	input  wire logic        rst,
	// User requests
	input  wire logic        reset_req,
	input  wire logic        cmd_req,
	input  wire logic [5:0]  cmd_index,
	input  wire logic [31:0] cmd_arg,
	input  wire logic        hs400_mode,
	output logic             busy,
	output logic             cmd_done,
	// Link
	ehr_link_if.host         link
);
	// ==========================================
	// Parameter check
	if (CLK_DIV < 2 || CLK_DIV > 512 || CLK_DIV % 2 != 0 || LOW_CYCLES < 1
		|| HIGH_CYCLES < 1 || WAIT_CYCLES < 1)
	begin : g_bad_param
		$error("ehr_host parameter out of range");
	end

	typedef enum logic [1:0] {HST_LOW, HST_WAIT, HST_IDLE, HST_SEND} ehr_host_state_t;
	ehr_host_state_t state;
	logic [31:0] count;
	logic [7:0]  clk_count;
	logic [7:0]  edges;
	logic        lclk;
	wire         tick = (clk_count == 8'(CLK_DIV / 2 - 1));
	wire         lclk_rise = tick && !lclk;
	wire         lclk_fall = tick && lclk;

	// ==========================================
	// Link clock divider and HS400 mode register
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			clk_count  <= 8'h00;
			lclk       <= 1'b0;
			link.hs400 <= 1'b0;
		end
		else
		begin
			clk_count <= tick ? 8'h00 : clk_count + 8'h01;
			if (tick)
				lclk <= ~lclk;
			// Mode moves on the falling link edge, settled at the next rise
			if (lclk_fall)
				link.hs400 <= hs400_mode;
		end
	end
	assign link.link_clock = lclk;

	// ==========================================
	// Reset and command sequencing
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state         <= HST_LOW;
			count         <= 32'h0;
			edges         <= 8'h00;
			link.reset_n  <= 1'b0;
			link.cmd_valid <= 1'b0;
			link.cmd_index <= 6'h00;
			link.cmd_arg   <= 32'h0;
			busy          <= 1'b1;
			cmd_done      <= 1'b0;
		end
		else
		begin
			cmd_done <= 1'b0;
			case (state)
				HST_LOW:
				begin
					count <= count + 32'h1;
					if (count >= 32'(LOW_CYCLES - 1)) // RQ4
					begin
						link.reset_n <= 1'b1;
						count        <= 32'h0;
						edges        <= 8'h00;
						state        <= HST_WAIT;
					end
				end
				HST_WAIT:
				begin
					count <= count + 32'h1;
					if (lclk_rise && edges != 8'hff)
						edges <= edges + 8'h01;
					if (count >= 32'(WAIT_CYCLES - 1) && count >= 32'(HIGH_CYCLES - 1)
						&& edges >= 8'(ehr_pkg::INIT_CLOCK_CYCLES)) // RQ5 RQ6
					begin
						busy  <= 1'b0;
						state <= HST_IDLE;
					end
				end
				HST_IDLE:
				begin
					if (reset_req)
					begin
						link.reset_n <= 1'b0;
						busy         <= 1'b1;
						count        <= 32'h0;
						state        <= HST_LOW;
					end
					else if (cmd_req)
					begin
						link.cmd_index <= cmd_index;
						link.cmd_arg   <= cmd_arg;
						busy           <= 1'b1;
						state          <= HST_SEND;
					end
				end
				HST_SEND:
				begin
					// Launch on the falling link edge, sampled on the next rise
					if (lclk_fall)
						link.cmd_valid <= 1'b1;
					if (link.cmd_valid && lclk_fall)
					begin
						link.cmd_valid <= 1'b0;
						cmd_done       <= 1'b1;
						busy           <= 1'b0;
						state          <= HST_IDLE;
					end
				end
				default: state <= HST_LOW;
			endcase
		end
	end
endmodule

// file: bench/ehr_asserts.sv
// Checker on the link between host end and device end.
// Assumes the link signals are fed in by name; host reset counts shortened to 4 link cycles.
`timescale 1ns/10ps
module ehr_asserts (
	// Link
	input wire logic       rst,
	input wire logic       link_clock,
	input wire logic       reset_n,
	input wire logic       cmd_valid,
	input wire logic [5:0] cmd_index,
	input wire logic       hs400,
	input wire logic       data_strobe_out,
	input wire logic       resp_valid,
	input wire logic       dev_ready
);
	// ==========================================
	// Link cycles since reset_n went high
	localparam int INIT_WAIT = ehr_pkg::INIT_CLOCK_CYCLES;
	int unsigned since;
	always_ff @(posedge link_clock or posedge rst)
		if (rst)
			since <= 0;
		else if (!reset_n)
			since <= 0;
		else if (since < 1000)
			since <= since + 1;
	default clocking @(posedge link_clock); endclocking
	default disable iff (rst);
	// ==========================================
	// Properties
	a_resp_after_cmd: assert property (cmd_valid |=> resp_valid)
		else $error("no response after command");
	a_resp_has_cmd: assert property (resp_valid |-> $past(cmd_valid))
		else $error("response without command");
	a_strobe_on_resp: assert property (hs400 && resp_valid |->
		##[0:2] (data_strobe_out != $past(data_strobe_out)))
		else $error("strobe idle during response");
	a_reset_low_width: assert property ($fell(reset_n) |-> !reset_n [*4])
		else $error("reset pulse too short");
	a_reset_high_gap: assert property ($rose(reset_n) |-> reset_n [*4])
		else $error("reset high interval too short");
	a_cmd_after_wait: assert property (cmd_valid |-> since >= INIT_WAIT)
		else $error("command too early after reset");
	a_no_cmd_reset: assert property (!reset_n |-> !cmd_valid)
		else $error("command during reset");
	a_ready_on_init: assert property (cmd_valid && cmd_index == ehr_pkg::CMD_SEND_OP
		|-> ##[1:3] dev_ready)
		else $error("device not ready after init command");
endmodule

// file: bench/emmc_hw_reset_and_strobe_ctrl_test.sv
// Bench joining host end and device end over the link.
// Assumes shortened host reset counts and a divided link clock.
`timescale 1ns/10ps
module emmc_hw_reset_and_strobe_ctrl_test;
	// ==========================================
	// Signals and model state
	logic        clock, rst, reset_req, cmd_req, hs400_mode, busy, cmd_done;
	logic [5:0]  cmd_index;
	logic [31:0] cmd_arg, seed, r;
	logic        pin_en, enh, rd, crc, op_done, op_fail, rd_valid, rd_err;
	logic [3:0]  req, limit, granted, lim;
	logic        retire, corrected, in_reset;
	int          n_mismatch, comparisons, toggles, resets, retires, fixes, ex_ret, ex_fix, t0;
	int          dones;
	ehr_link_if link ();
	ehr_host #(.LOW_CYCLES(40), .HIGH_CYCLES(40), .WAIT_CYCLES(200), .CLK_DIV(10)) i_ehr_host (
		.clock(clock), .rst(rst), .reset_req(reset_req), .cmd_req(cmd_req),
		.cmd_index(cmd_index), .cmd_arg(cmd_arg), .hs400_mode(hs400_mode), .busy(busy),
		.cmd_done(cmd_done), .link(link));
	ehr_device i_ehr_device (.link(link), .rst(rst), .reset_pin_enable(pin_en),
		.enh_partition_set(enh), .read_active(rd), .crc_status_active(crc),
		.preload_request(req), .flash_op_done(op_done), .flash_op_fail(op_fail),
		.flash_read_valid(rd_valid), .flash_read_err(rd_err), .preload_limit(limit),
		.preload_granted(granted), .block_retire(retire), .read_corrected(corrected),
		.in_reset(in_reset));
	ehr_asserts i_ehr_asserts (.rst(rst), .link_clock(link.link_clock), .reset_n(link.reset_n),
		.cmd_valid(link.cmd_valid), .cmd_index(link.cmd_index), .hs400(link.hs400),
		.data_strobe_out(link.data_strobe_out), .resp_valid(link.resp_valid),
		.dev_ready(link.dev_ready));
	always @(link.data_strobe_out) toggles++;
	always @(posedge in_reset) resets++;
	always @(posedge retire) retires++;
	always @(posedge corrected) fixes++;
	always @(posedge cmd_done) dones++;
	// ==========================================
	// Tasks
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic lk(int n);
		repeat (n) @(posedge link.link_clock);
		#1;
	endtask
	task automatic pulse_req(logic is_cmd, logic [5:0] idx);
		wait (busy === 1'b0);
		@(posedge clock);
		#1 {cmd_req, reset_req, cmd_index} = {is_cmd, !is_cmd, idx};
		@(posedge clock);
		#1 {cmd_req, reset_req} = 2'b00;
		wait (busy === 1'b0);
		lk(4);
	endtask
	task automatic results();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ==========================================
	// Clock, watchdog, main sequence
	initial
	begin
		clock = 0;
		forever #2 clock = ~clock;
	end
	initial
	begin
		#60000 n_mismatch++;
		results();
	end
	initial
	begin
		{rst, pin_en, seed, cmd_arg} = {2'b11, 32'h3d185208, 32'h0};
		{reset_req, cmd_req, hs400_mode, enh, rd, crc, op_done, op_fail, rd_valid, rd_err} = 0;
		{req, cmd_index} = 0;
		repeat (4) @(posedge clock);
		#1 rst = 0;
		pulse_req(1, ehr_pkg::CMD_SEND_OP);
		check("early reset", resets, 0);
		check("ready", link.dev_ready, 1);
		hs400_mode = 1;
		t0 = toggles;
		pulse_req(1, ehr_pkg::CMD_SEND_OP);
		check("strobe on response", toggles > t0, 1);
		lk(60);
		t0 = toggles;
		lk(20);
		check("strobe idle", toggles - t0, 0);
		for (int k = 1; k < 3; k++)
		begin
			t0 = toggles;
			{crc, rd} = 2'(k);
			lk(10);
			{crc, rd} = 2'b00;
			check("strobe read or crc", toggles > t0, 1);
		end
		t0 = resets;
		pulse_req(0, 6'h00);
		check("reset seen", resets - t0, 1);
		check("ready cleared", link.dev_ready, 0);
		pin_en = 0;
		pulse_req(0, 6'h00);
		check("reset ignored", resets - t0, 1);
		pulse_req(1, ehr_pkg::CMD_GO_IDLE);
		check("ready after reset", link.dev_ready, 1);
		check("commands done", dones, 3);
		for (int i = 0; i < 16; i++)
		begin
			r = rnd();
			{enh, op_fail, rd_err, req} = {i > 7, r[5:0]};
			{op_done, rd_valid} = 2'b11;
			lk(1);
			{op_done, rd_valid} = 2'b00;
			ex_ret += op_fail;
			ex_fix += rd_err;
			lim = i > 7 ? ehr_pkg::PRELOAD_ENH : ehr_pkg::PRELOAD_RESET;
			lk(3);
			check("limit", limit, lim);
			check("granted", granted, req < lim ? req : lim);
		end
		check("retired", retires, ex_ret);
		check("corrected", fixes, ex_fix);
		results();
	end
endmodule
